// *** core/ftc_core.sv ***
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
// How it works
// - Six sensors, own parameter sets, four fans
// - Start and full-power thresholds live per sensor
// - Fan takes one/two sensors or manual
// - Two sensors: higher demand drives fan
// - Below start-up temperature the fan stops
// - Hold option keeps minimum power instead
// - At or above maximum: full power
// - Linear ramp, progressive squared curve
// - Started fan stops below start minus hysteresis
// - Target mode: dead band of hysteresis
// - Target mode lowers demand below target
// - Alarm temperature closes the relay output
// - Temperature from log formula with calibration
// - Calibration offset and factor reset zero
// - Delay and factor only in target mode
// - Recalculate once per delay, default three seconds
// - Step equals factor times temperature error
module ftc_core
   import ftc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire ftc_apb_req_s                 apb_req,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [NUM_SEN-1:0][15:0]     sensor_raw,
   output logic [NUM_FAN-1:0][6:0]           fan_pwr,
   output logic                              relay_on
);
   ftc_state_s                   st_ff;
   ftc_state_s                   nxt_st;
   logic [NUM_SEN-1:0][9:0]      temp_now;
   logic [NUM_SEN-1:0]           alarm_hit;
   logic [NUM_FAN-1:0][6:0]      dem_a, dem_b;
   logic [NUM_FAN-1:0][1:0]      on_nxt;
   logic [NUM_FAN-1:0][10:0]     err_now;
   logic [NUM_FAN-1:0]           due, in_band;
   logic [NUM_FAN-1:0][6:0]      tgt_nxt;
   logic                         rd_hit;
   logic [31:0]                  rd_data;
   if (TICK_CYC < 2)
      $error("TICK_CYC must be at least 2");
   // Log2 by leading one plus linear mantissa; cheap and within about two and a half degrees
   function automatic logic [9:0] calc_temp(input logic [15:0] m, input ftc_sen_cfg_s c);
      logic [3:0]         pos;
      logic [15:0]        sh;
      logic signed [17:0] coef;
      logic signed [47:0] prod;
      logic signed [47:0] half;
      logic signed [47:0] res;
      pos = 4'h0;
      for (int i = 0; i < 16; i++)
         if (m[i])
            pos = 4'(i);
      sh   = m << (4'hF - pos);
      coef = 18'(FORM_COEF_HND) - 18'($signed(c.cal_fac));
      prod = 48'(coef) * 48'($signed({1'b0, pos, sh[14:7]}));
      prod = (prod * 48'(LN2_Q16)) >>> 24;
      half = (prod * 48'(DIV50_Q16)) >>> 16;
      res  = 48'(2 * FORM_BASE_DEG) + 48'($signed(c.cal_ofs)) - half;
      if (res > 48'sd511)
         res = 48'sd511;
      else if (res < -48'sd512)
         res = -48'sd512;
      return res[9:0];
   endfunction
   // Returns {running, percent}; band between off level and start keeps the last state
   function automatic logic [7:0] thr_dem(input logic [9:0] t, input ftc_sen_cfg_s c, input logic prog,
                                          input logic on);
      logic signed [10:0] ts, st, mx;
      logic [10:0]        du, span;
      logic [16:0]        lin;
      logic               run;
      ts  = 11'($signed(t));
      st  = $signed({3'b000, c.start});
      mx  = $signed({3'b000, c.maxt});
      run = on;
      if (ts >= st)
         run = 1'b1;
      else if (ts < st - $signed({3'b000, c.hyst}))
         run = 1'b0;
      du   = (ts > st) ? 11'(ts - st) : 11'h000;
      span = (mx > st) ? 11'(mx - st) : 11'h001;
      lin  = 17'((17'(du) * 17'h0_0064) / 17'(span));
      if (prog)
         lin = 17'((lin * lin) / 17'h0_0064);
      if (ts >= mx || mx <= st)
         lin = 17'(PWR_FULL);
      if (!run)
         lin = 17'h0_0000;
      return {run, lin[6:0]};
   endfunction
   // Conversion and alarm compare for every sensor channel
   for (genvar s = 0; s < NUM_SEN; s++)
   begin : g_sen
      assign temp_now[s]  = calc_temp(st_ff.meas[s], st_ff.sen[s]);
      assign alarm_hit[s] = $signed(temp_now[s]) >= $signed({2'b00, st_ff.sen[s].alarm});
   end
   // Per fan: slot demands from its sensors, governing error and regulator step
   for (genvar f = 0; f < NUM_FAN; f++)
   begin : g_fan
      ftc_fan_cfg_s       fc;
      logic               va, vb, use_b;
      logic [2:0]         ia, ib, ig;
      logic [7:0]         ra, rb;
      logic signed [10:0] ea, eb, stp, sum, lo;
      logic signed [18:0] stw;
      assign fc    = st_ff.fan[f];
      assign va    = fc.sel_a != 3'h0 && fc.sel_a <= 3'(NUM_SEN);
      assign vb    = fc.sel_b != 3'h0 && fc.sel_b <= 3'(NUM_SEN);
      assign ia    = va ? fc.sel_a - 3'h1 : 3'h0;
      assign ib    = vb ? fc.sel_b - 3'h1 : 3'h0;
      assign ra    = thr_dem(temp_now[ia], st_ff.sen[ia], fc.mode == FTC_PROG, st_ff.on[f][0]);
      assign rb    = thr_dem(temp_now[ib], st_ff.sen[ib], fc.mode == FTC_PROG, st_ff.on[f][1]);
      assign dem_a[f]  = va ? ra[6:0] : 7'h00;
      assign dem_b[f]  = vb ? rb[6:0] : 7'h00;
      assign on_nxt[f] = {vb & rb[7], va & ra[7]};
      assign ea    = 11'($signed(temp_now[ia])) - $signed({3'b000, st_ff.sen[ia].target});
      assign eb    = 11'($signed(temp_now[ib])) - $signed({3'b000, st_ff.sen[ib].target});
      assign use_b = vb && (!va || eb > ea);
      assign ig    = use_b ? ib : ia;
      assign err_now[f] = use_b ? eb : ea;
      assign due[f] = (9'(st_ff.dly_cnt[f]) + 9'h001) >= {1'b0, st_ff.sen[ig].delay};
      assign in_band[f] = $signed(err_now[f]) <= $signed({3'b000, st_ff.sen[ig].hyst}) &&
                          $signed(err_now[f]) >= -$signed({3'b000, st_ff.sen[ig].hyst});
      // Error is in half degrees, so the product is halved; clipped at 200 since more only saturates the fan
      assign stw   = (19'($signed(err_now[f])) * 19'($signed({1'b0, st_ff.sen[ig].factor}))) >>> 1;
      assign stp   = (stw > 19'sd200) ? 11'sd200 : (stw < -19'sd200) ? -11'sd200 : stw[10:0];
      assign sum   = $signed({4'h0, st_ff.tgt_pwr[f]}) + stp;
      assign lo    = fc.hold ? $signed({4'h0, fc.min_pwr}) : 11'sd0;
      assign tgt_nxt[f] = (sum > 11'sd100) ? PWR_FULL : (sum < lo) ? lo[6:0] : sum[6:0];
   end
   // Register read decode, shared by the data latch and the error answer
   always_comb
   begin
      rd_hit  = 1'b0;
      rd_data = 32'h0000_0000;
      unique case (apb_req.paddr[11:8])
         REG_SEN_PAGE:
         begin
            rd_hit = apb_req.paddr[7:5] < 3'(NUM_SEN);
            unique case (apb_req.paddr[4:2])
               SEN_START:   rd_data[7:0]  = st_ff.sen[apb_req.paddr[7:5]].start;
               SEN_MAX:     rd_data[7:0]  = st_ff.sen[apb_req.paddr[7:5]].maxt;
               SEN_ALARM:   rd_data[7:0]  = st_ff.sen[apb_req.paddr[7:5]].alarm;
               SEN_HYST:    rd_data[7:0]  = st_ff.sen[apb_req.paddr[7:5]].hyst;
               SEN_TARGET:  rd_data[7:0]  = st_ff.sen[apb_req.paddr[7:5]].target;
               SEN_CAL_OFS: rd_data[7:0]  = st_ff.sen[apb_req.paddr[7:5]].cal_ofs;
               SEN_CAL_FAC: rd_data[15:0] = st_ff.sen[apb_req.paddr[7:5]].cal_fac;
               SEN_CTRL:    rd_data[15:0] = {st_ff.sen[apb_req.paddr[7:5]].factor,
                                             st_ff.sen[apb_req.paddr[7:5]].delay};
            endcase
         end
         REG_FAN_PAGE:
         begin
            rd_hit = apb_req.paddr[7:6] == 2'b00;
            unique case (apb_req.paddr[3:2])
               FAN_CFG:  rd_data[12:0] = {st_ff.fan[apb_req.paddr[5:4]].hold, 1'b0,
                                          st_ff.fan[apb_req.paddr[5:4]].sel_b, 1'b0,
                                          st_ff.fan[apb_req.paddr[5:4]].sel_a, 2'b00,
                                          st_ff.fan[apb_req.paddr[5:4]].mode};
               FAN_MIN:  rd_data[6:0] = st_ff.fan[apb_req.paddr[5:4]].min_pwr;
               FAN_MAN:  rd_data[6:0] = st_ff.fan[apb_req.paddr[5:4]].man_pwr;
               FAN_STAT: rd_data[6:0] = st_ff.pwr[apb_req.paddr[5:4]];
            endcase
         end
         REG_STA_PAGE:
         begin
            rd_hit = apb_req.paddr[7:2] <= STA_ALARM;
            if (apb_req.paddr[7:2] == STA_ALARM)
               rd_data[0] = st_ff.relay;
            else if (apb_req.paddr[7:2] < STA_ALARM)
               rd_data = 32'($signed(st_ff.temp[apb_req.paddr[4:2]]));
         end
         default: rd_hit = 1'b0;
      endcase
      if (!rd_hit)                 // Unmapped reads as zero; also hides an out-of-range sensor index
         rd_data = 32'h0000_0000;
   end
   // Next-state: pin sync, second tick, regulation, register writes
   always_comb
   begin
      nxt_st = st_ff;
      // Three stages; a reading counts once the last two agree
      nxt_st.raw_sync[0] = sensor_raw;
      nxt_st.raw_sync[1] = st_ff.raw_sync[0];
      nxt_st.raw_sync[2] = st_ff.raw_sync[1];
      for (int s = 0; s < NUM_SEN; s++)
         if (st_ff.raw_sync[1][s] == st_ff.raw_sync[2][s])
            nxt_st.meas[s] = st_ff.raw_sync[2][s];
      nxt_st.tick = 1'b0;
      if (st_ff.tick_cnt >= 32'(TICK_CYC - 1))
      begin
         nxt_st.tick_cnt = 32'h0000_0000;
         nxt_st.tick     = 1'b1;
      end
      else
         nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
      if (st_ff.tick)
      begin
         nxt_st.temp  = temp_now;
         nxt_st.relay = |alarm_hit;
         for (int f = 0; f < NUM_FAN; f++)
         begin
            nxt_st.on[f] = on_nxt[f];
            unique case (st_ff.fan[f].mode)
               FTC_MANUAL:
                  nxt_st.pwr[f] = st_ff.fan[f].man_pwr;
               FTC_LINEAR, FTC_PROG:
               begin
                  nxt_st.pwr[f] = (dem_a[f] > dem_b[f]) ? dem_a[f] : dem_b[f];
                  // A running fan never drops under its minimum; with hold it never stops
                  if ((|on_nxt[f] || st_ff.fan[f].hold) && nxt_st.pwr[f] < st_ff.fan[f].min_pwr)
                     nxt_st.pwr[f] = st_ff.fan[f].min_pwr;
               end
               FTC_TARGET:
               begin
                  // Delay counter runs only in this mode, so other modes ignore it
                  nxt_st.dly_cnt[f] = st_ff.dly_cnt[f] + 8'h01;
                  if (due[f])
                  begin
                     nxt_st.dly_cnt[f] = 8'h00;
                     if (!in_band[f])
                        nxt_st.tgt_pwr[f] = tgt_nxt[f];
                  end
                  nxt_st.pwr[f] = nxt_st.tgt_pwr[f];
                  if (st_ff.fan[f].sel_a == 3'h0 && st_ff.fan[f].sel_b == 3'h0)
                     nxt_st.pwr[f] = 7'h00;
               end
            endcase
         end
      end
      // Writes land in the access phase; pready is always high
      if (apb_req.psel && apb_req.penable && apb_req.pwrite && rd_hit)
      begin
         unique case (apb_req.paddr[11:8])
            REG_SEN_PAGE:
               unique case (apb_req.paddr[4:2])
                  SEN_START:   nxt_st.sen[apb_req.paddr[7:5]].start   = apb_req.pwdata[7:0];
                  SEN_MAX:     nxt_st.sen[apb_req.paddr[7:5]].maxt    = apb_req.pwdata[7:0];
                  SEN_ALARM:   nxt_st.sen[apb_req.paddr[7:5]].alarm   = apb_req.pwdata[7:0];
                  SEN_HYST:    nxt_st.sen[apb_req.paddr[7:5]].hyst    =
                     (apb_req.pwdata[7:0] > HYST_MAX) ? HYST_MAX : apb_req.pwdata[7:0];
                  SEN_TARGET:  nxt_st.sen[apb_req.paddr[7:5]].target  =
                     (apb_req.pwdata[7:0] > TARGET_MAX) ? TARGET_MAX : apb_req.pwdata[7:0];
                  SEN_CAL_OFS: nxt_st.sen[apb_req.paddr[7:5]].cal_ofs = apb_req.pwdata[7:0];
                  SEN_CAL_FAC: nxt_st.sen[apb_req.paddr[7:5]].cal_fac = apb_req.pwdata[15:0];
                  SEN_CTRL:
                  begin
                     nxt_st.sen[apb_req.paddr[7:5]].delay  = apb_req.pwdata[7:0];
                     nxt_st.sen[apb_req.paddr[7:5]].factor = apb_req.pwdata[15:8];
                  end
               endcase
            REG_FAN_PAGE:
               unique case (apb_req.paddr[3:2])
                  FAN_CFG:
                  begin
                     nxt_st.fan[apb_req.paddr[5:4]].mode  = ftc_mode_e'(apb_req.pwdata[1:0]);
                     nxt_st.fan[apb_req.paddr[5:4]].sel_a = apb_req.pwdata[6:4];
                     nxt_st.fan[apb_req.paddr[5:4]].sel_b = apb_req.pwdata[10:8];
                     nxt_st.fan[apb_req.paddr[5:4]].hold  = apb_req.pwdata[12];
                  end
                  FAN_MIN: nxt_st.fan[apb_req.paddr[5:4]].min_pwr =
                     (apb_req.pwdata[6:0] > PWR_FULL) ? PWR_FULL : apb_req.pwdata[6:0];
                  FAN_MAN: nxt_st.fan[apb_req.paddr[5:4]].man_pwr =
                     (apb_req.pwdata[6:0] > PWR_FULL) ? PWR_FULL : apb_req.pwdata[6:0];
                  FAN_STAT: nxt_st.fan[apb_req.paddr[5:4]] = st_ff.fan[apb_req.paddr[5:4]];
               endcase
            default: ;            // Status page is read-only; a tick update in this cycle must survive
         endcase
      end
      // Read data is captured in the setup phase so prdata comes from a flop
      if (apb_req.psel && !apb_req.penable)
         nxt_st.prdata = rd_data;
   end

   // State register; reset values are all constants
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= '0;
         for (int s = 0; s < NUM_SEN; s++)
            st_ff.sen[s] <= '{RST_START, RST_MAX, RST_ALARM, RST_HYST, RST_TARGET,
                              RST_CALOFS, RST_CALFAC, RST_DELAY, RST_FACTOR};
         for (int f = 0; f < NUM_FAN; f++)
            st_ff.fan[f] <= '{FTC_MANUAL, 3'h0, 3'h0, 1'b0, RST_MINPWR, RST_MANPWR};
      end
      else
         st_ff <= nxt_st;
   end

   assign prdata   = st_ff.prdata;
   assign pready   = 1'b1;
   assign pslverr  = apb_req.psel && apb_req.penable && !rd_hit;
   assign fan_pwr  = st_ff.pwr;
   assign relay_on = st_ff.relay;
   // Checks on fan 0 stand for all four channels
   AST_RELAY_ALARM: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && (|alarm_hit) |=> relay_on) else $error("relay not raised on alarm");
   AST_MANUAL: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_MANUAL |=> fan_pwr[0] == $past(st_ff.fan[0].man_pwr))
      else $error("manual power not applied");
   AST_FULL_POWER: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_LINEAR && dem_a[0] == PWR_FULL |=> fan_pwr[0] == PWR_FULL)
      else $error("full power not reached");
   AST_OFF_BELOW: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_LINEAR && !st_ff.fan[0].hold && on_nxt[0] == 2'b00
      |=> fan_pwr[0] == 7'h00) else $error("fan not off below start");
   AST_HOLD_MIN: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_LINEAR && st_ff.fan[0].hold && on_nxt[0] == 2'b00
      |=> fan_pwr[0] == $past(st_ff.fan[0].min_pwr)) else $error("minimum power not held");
   AST_TWO_SENSORS: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_PROG && dem_a[0] >= st_ff.fan[0].min_pwr
      |=> fan_pwr[0] >= $past(dem_a[0]) && fan_pwr[0] >= $past(dem_b[0]))
      else $error("lower sensor demand used");
   AST_RECALC_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(st_ff.tgt_pwr[0]) |-> $past(st_ff.tick) && $past(due[0]))
      else $error("regulator recalculated too early");
   AST_DEADBAND: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && in_band[0] |=> $stable(st_ff.tgt_pwr[0])) else $error("change inside dead band");
   AST_TARGET_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_TARGET && due[0] && !in_band[0]
      |=> st_ff.tgt_pwr[0] == $past(tgt_nxt[0]) ##1 fan_pwr[0] == $past(st_ff.tgt_pwr[0]))
      else $error("target step wrong");
   AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick |=> !st_ff.tick [*1] ##0 st_ff.temp == $past(temp_now)) else $error("tick or update wrong");
   COV_TARGET_STEP: cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.fan[0].mode == FTC_TARGET && due[0] && !in_band[0]);
   COV_ALARM: cover property (@(posedge pclk) disable iff (!presetn) $rose(relay_on));
   COV_HYST_BAND: cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick && st_ff.on[0][0] && on_nxt[0][0] && dem_a[0] == 7'h00);
endmodule

// *** core/ftc_pkg.sv ***
package ftc_pkg;
   // Channel counts
   localparam int NUM_SEN = 6;
   localparam int NUM_FAN = 4;
   // Timing: one evaluation per second
   localparam int CLK_HZ      = 25_000_000;
   localparam int TICK_S      = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_S;
   // Conversion: base in degrees, slope in hundredths, ln2 in Q16
   localparam int FORM_BASE_DEG = 237;
   localparam int FORM_COEF_HND = 4415;
   localparam int LN2_Q16       = 45426;
   localparam int DIV50_Q16     = 1311;
   // Limits in half degrees and percent
   localparam logic [7:0] HYST_MAX   = 8'h32;
   localparam logic [7:0] TARGET_MAX = 8'hC8;
   localparam logic [6:0] PWR_FULL   = 7'h64;
   // Register map: sensor block, fan block, status block
   localparam logic [3:0] REG_SEN_PAGE = 4'h0;
   localparam logic [3:0] REG_FAN_PAGE = 4'h1;
   localparam logic [3:0] REG_STA_PAGE = 4'h2;
   localparam logic [2:0] SEN_START = 3'h0, SEN_MAX = 3'h1, SEN_ALARM = 3'h2, SEN_HYST = 3'h3;
   localparam logic [2:0] SEN_TARGET = 3'h4, SEN_CAL_OFS = 3'h5, SEN_CAL_FAC = 3'h6, SEN_CTRL = 3'h7;
   localparam logic [1:0] FAN_CFG = 2'h0, FAN_MIN = 2'h1, FAN_MAN = 2'h2, FAN_STAT = 2'h3;
   localparam logic [5:0] STA_ALARM = 6'h06;
   // Values after reset
   localparam logic [7:0]  RST_START  = 8'h3C;
   localparam logic [7:0]  RST_MAX    = 8'h64;
   localparam logic [7:0]  RST_ALARM  = 8'h8C;
   localparam logic [7:0]  RST_HYST   = 8'h00;
   localparam logic [7:0]  RST_TARGET = 8'h3C;
   localparam logic [7:0]  RST_CALOFS = 8'h00;
   localparam logic [15:0] RST_CALFAC = 16'h0000;
   localparam logic [7:0]  RST_DELAY  = 8'h03;
   localparam logic [7:0]  RST_FACTOR = 8'h02;
   localparam logic [6:0]  RST_MINPWR = 7'h19;
   localparam logic [6:0]  RST_MANPWR = 7'h64;

   typedef enum logic [1:0] {FTC_MANUAL, FTC_LINEAR, FTC_PROG, FTC_TARGET} ftc_mode_e;

   typedef struct packed {
      logic [7:0]  start, maxt, alarm, hyst, target, cal_ofs;
      logic [15:0] cal_fac;
      logic [7:0]  delay, factor;
   } ftc_sen_cfg_s;

   typedef struct packed {
      ftc_mode_e  mode;
      logic [2:0] sel_a, sel_b;
      logic       hold;
      logic [6:0] min_pwr, man_pwr;
   } ftc_fan_cfg_s;

   typedef struct packed {
      logic        psel, penable, pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ftc_apb_req_s;

   typedef struct packed {
      ftc_sen_cfg_s [NUM_SEN-1:0]          sen;
      ftc_fan_cfg_s [NUM_FAN-1:0]          fan;
      logic [2:0][NUM_SEN-1:0][15:0]       raw_sync;
      logic [NUM_SEN-1:0][15:0]            meas;
      logic [NUM_SEN-1:0][9:0]             temp;
      logic [NUM_FAN-1:0][1:0]             on;
      logic [NUM_FAN-1:0][6:0]             pwr, tgt_pwr;
      logic [NUM_FAN-1:0][7:0]             dly_cnt;
      logic [31:0]                         tick_cnt;
      logic                                tick, relay;
      logic [31:0]                         prdata;
   } ftc_state_s;
endpackage

// *** dv/ftc_sensor_model.sv ***
`timescale 1ns/100ps
// Far side: six thermistor front ends presenting raw counts to the core
module ftc_sensor_model
   import ftc_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic [NUM_SEN-1:0][15:0] level,
   output logic [NUM_SEN-1:0][15:0]      sensor_raw
);
   // Counts move just after an edge, as a sampled converter would; cold reading until then
   initial sensor_raw = '1;
   always @(posedge pclk)
   begin
      sensor_raw <= level;
   end
endmodule

// *** dv/fan_thermal_controller_bench.sv ***
`timescale 1ns/100ps
// Register traffic over APB, fan demand judged a few ticks after each change
module fan_thermal_controller_bench
   import ftc_pkg::*;
;
   localparam int          TCYC = 20;
   localparam logic [15:0] HOT  = 16'h0001;
   localparam logic [15:0] COLD = 16'hFFFF;
   localparam logic [15:0] MID  = 16'h0100;
   typedef struct packed {logic [31:0] d; logic e;} ftc_note_s;
   logic                     pclk = 1'b0;
   logic                     presetn = 1'b0;
   ftc_apb_req_s             req = '0;
   logic [31:0]              prdata, m;
   logic                     pready, pslverr, relay_on;
   logic [NUM_SEN-1:0][15:0] level, sensor_raw;
   logic [NUM_FAN-1:0][6:0]  fan_pwr;
   ftc_note_s                apb_q[$], fan_q[$], na, nf;
   int                       fails = 0, n_checks = 0, seed = 32'h0000_6fbd;
   event                     probe;
   logic [31:0]              rstv [8] = '{32'h0000_003C, 32'h0000_0064, 32'h0000_008C, 32'h0000_0000,
                                          32'h0000_003C, 32'h0000_0000, 32'h0000_0000, 32'h0000_0203};

   always #20 pclk = ~pclk;

   ftc_core #(.TICK_CYC(TCYC)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sensor_raw(sensor_raw), .fan_pwr(fan_pwr), .relay_on(relay_on));
   ftc_sensor_model far (.pclk(pclk), .level(level), .sensor_raw(sensor_raw));

   // One transfer; request held until pready is seen, then released for a cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
                      input logic e);
      apb_q.push_back('{x, e});
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      req <= '0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0, 1'b0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, '0, x, 1'b0);
   endtask
   // Ticks come every TCYC cycles; three allow for the input sync and the update pipeline
   task automatic chk(input int k, input logic [6:0] p, input logic r);
      repeat (k * TCYC) @(posedge pclk);
      fan_q.push_back('{{24'h0000_00, r, p}, 1'b0});
      @(negedge pclk);
      -> probe;
      @(posedge pclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Access cycles against the oldest register note; read data only matters on reads
   always @(posedge pclk)
   begin
      if (req.psel && req.penable && pready === 1'b1)
      begin
         na = apb_q.pop_front();
         n_checks++;
         if (pslverr !== na.e || (!req.pwrite && prdata !== na.d))
         begin
            fails++;
            $display("mismatch apb %h expected %h/%b seen %h/%b", req.paddr, na.d, na.e, prdata, pslverr);
         end
      end
   end

   // Fan 0 demand and relay against the oldest fan note; untouched fans stay at manual power
   always @(probe)
   begin
      nf = fan_q.pop_front();
      n_checks++;
      if ({relay_on, fan_pwr[0]} !== nf.d[7:0])
      begin
         fails++;
         $display("mismatch fan0/relay expected %h seen %h", nf.d[7:0], {relay_on, fan_pwr[0]});
      end
      n_checks++;
      if (fan_pwr[3:1] !== {3{RST_MANPWR}})
      begin
         fails++;
         $display("mismatch fan1-3 expected %h seen %h", {3{RST_MANPWR}}, fan_pwr[3:1]);
      end
   end

   // Watchdog, far beyond the roughly 1500 cycles the sequence needs
   initial
   begin
      repeat (20_000) @(posedge pclk);
      fails++;
      report_and_stop();
   end

   // Main sequence; idle channels get deep-cold random counts so they never trip the relay
   initial
   begin
      level[0] = HOT;
      level[1] = COLD;
      for (int i = 2; i < NUM_SEN; i++) level[i] = {2'b11, 14'($random(seed))};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int s = 0; s < NUM_SEN; s++)
         for (int i = 0; i < 8; i++)
            rd(12'(s * 32 + i * 4), rstv[i]);
      apb(1'b0, 12'h0C0, '0, '0, 1'b1);
      apb(1'b1, 12'h300, '1, '0, 1'b1);
      wr(12'h00C, 32'h0000_00FF);
      rd(12'h00C, 32'h0000_0032);
      wr(12'h010, 32'h0000_00FF);
      rd(12'h010, 32'h0000_00C8);
      wr(12'h010, 32'h0000_003C);
      chk(3, 7'h64, 1'b1);
      m = 32'($unsigned($random(seed)) % 101);
      wr(12'h108, m);
      chk(3, m[6:0], 1'b1);
      rd(12'h10C, m);
      rd(12'h200, 32'h0000_01DA);
      wr(12'h018, 32'h0000_113F);
      level[0] <= COLD;
      chk(3, m[6:0], 1'b1);
      rd(12'h200, 32'h0000_01DA);
      wr(12'h018, 32'h0000_0000);
      level[0] <= HOT;
      wr(12'h014, 32'h0000_0064);
      wr(12'h000, 32'h0000_0064);
      wr(12'h004, 32'h0000_0078);
      wr(12'h00C, 32'h0000_0028);
      for (int md = 1; md < 3; md++)
      begin
         wr(12'h100, 32'(md + 16));
         chk(3, 7'h64, 1'b1);
      end
      level[0] <= MID;
      chk(3, 7'h19, 1'b0);
      level[0] <= COLD;
      chk(3, 7'h00, 1'b0);
      level[0] <= MID;
      chk(3, 7'h00, 1'b0);
      wr(12'h100, 32'h0000_1012);
      chk(3, 7'h19, 1'b0);
      wr(12'h100, 32'h0000_0211);
      level[1] <= HOT;
      chk(3, 7'h64, 1'b1);
      level[1] <= COLD;
      level[0] <= HOT;
      wr(12'h100, 32'h0000_0013);
      chk(6, 7'h64, 1'b1);
      level[0] <= MID;
      wr(12'h010, 32'h0000_0054);
      chk(6, 7'h64, 1'b0);
      level[0] <= COLD;
      wr(12'h100, 32'h0000_1013);
      chk(6, 7'h19, 1'b0);
      wr(12'h010, 32'h0000_0000);
      level[0] <= MID;
      chk(6, 7'h64, 1'b0);
      wr(12'h000, 32'h0000_0046);
      wr(12'h104, 32'h0000_0000);
      wr(12'h100, 32'h0000_0011);
      chk(3, 7'h1E, 1'b0);
      wr(12'h100, 32'h0000_0012);
      chk(3, 7'h09, 1'b0);
      report_and_stop();
   end
endmodule
